// ===== hdl/flash_power_ctrl.sv
// Purpose: Host controller driving an asynchronous boot-block flash via its pins
// Assumes: Flash pins sampled through two flip-flops; flash has no clock
// Notes:   Software orders reset release, reads, command writes and polls
//
// Overview of operation
// RL1: Flash refuses program/erase with low program supply, sets supply fault flag.
// RL2: Flash is active while select low and reset/power-down high.
// RL3: Flash saves power after reads but keeps last data driven.
// RL4: Select high in read mode floats outputs; standby.
// RL5: Select high during program/erase lets operation finish first.
// RL6: Reset/power-down low gives deep power-down and floats outputs.
// RL7: Host waits recovery time after reset release before expecting read data.
// RL8: Reset/power-down falling mid program/erase aborts it; content undefined.
// RL9: Status register cleared when reset/power-down goes low.
// RL10: Tie flash reset/power-down to processor reset so it returns to array.
// RL11: Command writes only while write strobe and select both low.
// RL12: Array alters only after a full two-cycle command sequence.
// RL13: While reset/power-down low, flash ignores all control inputs.
// RL14: Last latched command held across supply, select and engine changes.
// RL15: Command interface starts in read-array after power-up or reset.
// RL16: After program/erase host issues read-array before reading array data.
// RL17: No program/erase started during power transitions.
// RL18: Status bit 7 is engine ready; host checks it before error bits.
// RL19: Supply levels are digital qualifier inputs sampled by the logic.
`timescale 1ns/10ps
`default_nettype none
`include "flash_pm_map.svh"
module flash_power_ctrl #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
) (
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire flash_pm_pkg::regAddr_t regAddr,
  input  wire flash_pm_pkg::word_t  regWdata,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output var  flash_pm_pkg::word_t  regRdata,
  output var  logic                 irq,
  input  wire logic                 coreSupplyOk,
  input  wire logic                 progSupplyOk,
  output var  logic                 resetPowerdown_n,
  output var  logic                 chipSelect_n,
  output var  logic                 writeStrobe_n,
  output var  logic                 outputGate_n,
  output var  logic [ADDR_W-1:0]    flashAddr,
  output var  logic [DATA_W-1:0]    dataOut,
  output var  logic                 dataOe,
  input  wire logic [DATA_W-1:0]    dataIn
);
  import flash_pm_pkg::*;

  initial begin
    if (ADDR_W < 1 || ADDR_W > 32 || DATA_W < 8 || DATA_W > 32) begin
      $error("flash_power_ctrl: unsupported ADDR_W or DATA_W");
    end
  end

  localparam logic [7:0] RECOVERY_CYC = 8'(`RECOVERY_CYC);
  localparam logic [7:0] STROBE_CYC   = 8'(`STROBE_CYC);

  function automatic logic regHit(input regAddr_t a, input regAddr_t b);
    regHit = (a == b);
  endfunction : regHit

  // Two-flop synchronisers for supply qualifiers and data pins
  logic [1:0]        coreSync_r;
  logic [1:0]        progSync_r;
  logic [DATA_W-1:0] dataMeta_r;
  logic [DATA_W-1:0] dataSync_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      coreSync_r <= 2'h0;
      progSync_r <= 2'h0;
      dataMeta_r <= '0;
      dataSync_r <= '0;
    end else begin
      coreSync_r <= {coreSync_r[0], coreSupplyOk}; // [RL19]
      progSync_r <= {progSync_r[0], progSupplyOk}; // [RL19]
      dataMeta_r <= dataIn;
      dataSync_r <= dataMeta_r;
    end
  end
  logic coreOk;
  logic progOk;
  assign coreOk = coreSync_r[1];
  assign progOk = progSync_r[1];

  fsmState_e         state_r,    state_nxt;
  logic [7:0]        count_r,    count_nxt;
  logic              release_r,  release_nxt;
  logic              select_r,   select_nxt;
  logic [2:0]        cmd_r,      cmd_nxt;
  logic              go_r,       go_nxt;
  logic [ADDR_W-1:0] addr_r,     addr_nxt;
  logic [DATA_W-1:0] wdata_r,    wdata_nxt;
  logic [DATA_W-1:0] rdata_r,    rdata_nxt;
  logic [7:0]        status_r,   status_nxt;
  logic              needArray_r, needArray_nxt;
  logic              engineBusy_r, engineBusy_nxt;
  logic [2:0]        irqStat_r,  irqStat_nxt;
  logic [2:0]        irqMask_r,  irqMask_nxt;
  logic              phase2_r,   phase2_nxt;
  word_t             rdOut_r,    rdOut_nxt;
  logic              csN_r,      csN_nxt;
  logic              weN_r,      weN_nxt;
  logic              oeN_r,      oeN_nxt;
  logic              drive_r,    drive_nxt;
  logic [DATA_W-1:0] pinData_r,  pinData_nxt;

  logic [2:0] evt;

  always_comb begin
    state_nxt      = state_r;
    count_nxt      = count_r;
    release_nxt    = release_r;
    select_nxt     = select_r;
    cmd_nxt        = cmd_r;
    go_nxt         = 1'b0;
    addr_nxt       = addr_r;
    wdata_nxt      = wdata_r;
    rdata_nxt      = rdata_r;
    status_nxt     = status_r;
    needArray_nxt  = needArray_r;
    engineBusy_nxt = engineBusy_r;
    irqMask_nxt    = irqMask_r;
    phase2_nxt     = phase2_r;
    csN_nxt        = 1'b1;
    weN_nxt        = 1'b1;
    oeN_nxt        = 1'b1;
    drive_nxt      = 1'b0;
    pinData_nxt    = pinData_r;
    evt            = 3'h0;
    rdOut_nxt      = 32'h0;

    if (regWr) begin
      if (regHit(regAddr, `REG_CTRL)) begin
        release_nxt = regWdata[`CTRL_RESET_REL];
        select_nxt  = regWdata[`CTRL_SELECT];
      end else if (regHit(regAddr, `REG_CMD)) begin
        cmd_nxt = regWdata[2:0];
        go_nxt  = 1'b1;
      end else if (regHit(regAddr, `REG_ADDR)) begin
        addr_nxt = regWdata[ADDR_W-1:0];
      end else if (regHit(regAddr, `REG_WDATA)) begin
        wdata_nxt = regWdata[DATA_W-1:0];
      end else if (regHit(regAddr, `REG_IRQ_MASK)) begin
        irqMask_nxt = regWdata[2:0];
      end
    end

    // Flash under reset or core supply low: hold it down, nothing issued
    if (!release_r || !coreOk) begin // [RL10] [RL17]
      if (state_r != ST_DOWN && engineBusy_r) begin
        evt[`IRQ_FAULT] = 1'b1; // [RL8]
      end
      state_nxt      = ST_DOWN;
      status_nxt     = 8'h80; // [RL9]
      engineBusy_nxt = 1'b0;
      needArray_nxt  = 1'b0; // [RL15]
      phase2_nxt     = 1'b0;
    end else begin
      case (state_r)
        ST_DOWN: begin
          state_nxt = ST_RECOVER;
          count_nxt = RECOVERY_CYC;
        end
        ST_RECOVER: begin
          if (count_r <= 8'h1) begin // [RL7]
            state_nxt = ST_IDLE;
            evt[`IRQ_RECOVERED] = 1'b1;
          end else begin
            count_nxt = count_r - 8'h1;
          end
        end
        ST_IDLE: begin
          if (go_r) begin
            count_nxt = STROBE_CYC;
            case (cmd_r)
              `CMD_READ: state_nxt = ST_READ;
              `CMD_POLL: state_nxt = ST_POLL;
              `CMD_WRITE: begin
                state_nxt = ST_WRITE;
                pinData_nxt = wdata_r;
              end
              `CMD_PROGRAM: begin
                if (!progOk) begin // [RL1] [RL17]
                  status_nxt[`SR_SUPPLY_FAULT] = 1'b1;
                  evt[`IRQ_FAULT] = 1'b1;
                end else begin
                  state_nxt   = ST_WRITE;
                  phase2_nxt  = 1'b1; // [RL12]
                  pinData_nxt = DATA_W'(`CODE_PROGRAM);
                end
              end
              default: state_nxt = ST_IDLE;
            endcase
          end
        end
        ST_WRITE: begin
          csN_nxt   = 1'b0; // [RL11]
          weN_nxt   = (count_r <= 8'h1);
          drive_nxt = 1'b1;
          if (!phase2_r && count_r == STROBE_CYC) begin // Data moves with strobe fall, not rise
            pinData_nxt = wdata_r; // [RL12]
          end
          if (count_r <= 8'h1) begin
            if (phase2_r) begin
              phase2_nxt  = 1'b0;
              count_nxt   = STROBE_CYC;
              engineBusy_nxt = 1'b1;
              needArray_nxt  = 1'b1;
            end else begin
              state_nxt = ST_IDLE;
              if (wdata_r == DATA_W'(`CODE_READ_ARRAY)) begin
                needArray_nxt = 1'b0; // [RL16]
              end
            end
          end else begin
            count_nxt = count_r - 8'h1;
          end
        end
        ST_READ, ST_POLL: begin
          csN_nxt = 1'b0; // [RL2]
          oeN_nxt = (count_r == 8'h0); // Synced pins lag the gate by two flops
          if (count_r == 8'h0) begin
            state_nxt = ST_IDLE;
            if (state_r == ST_POLL) begin
              status_nxt = dataSync_r[7:0];
              if (dataSync_r[`SR_ENGINE_READY] && engineBusy_r) begin // [RL18]
                engineBusy_nxt = 1'b0;
                evt[`IRQ_DONE] = 1'b1;
                if (dataSync_r[`SR_SUPPLY_FAULT]) begin
                  evt[`IRQ_FAULT] = 1'b1;
                end
              end
            end else begin
              rdata_nxt = dataSync_r;
            end
          end else begin
            count_nxt = count_r - 8'h1;
          end
        end
        default: state_nxt = ST_DOWN;
      endcase
      // Select held low between cycles when software asks
      if (select_r && state_r == ST_IDLE) begin
        csN_nxt = 1'b0;
      end
    end

    // Status bits: hardware set wins over write-one clear
    irqStat_nxt = irqStat_r;
    if (regWr && regHit(regAddr, `REG_IRQ_STAT)) begin
      irqStat_nxt = irqStat_r & ~regWdata[2:0];
    end
    irqStat_nxt = irqStat_nxt | evt;

    if (regRd) begin
      if (regHit(regAddr, `REG_CTRL)) begin
        rdOut_nxt = {30'h0, select_r, release_r};
      end else if (regHit(regAddr, `REG_CMD)) begin
        rdOut_nxt = {29'h0, cmd_r};
      end else if (regHit(regAddr, `REG_ADDR)) begin
        rdOut_nxt = 32'(addr_r);
      end else if (regHit(regAddr, `REG_WDATA)) begin
        rdOut_nxt = 32'(wdata_r);
      end else if (regHit(regAddr, `REG_STATUS)) begin
        rdOut_nxt = {16'h0, 3'h0, progOk, coreOk, needArray_r, engineBusy_r,
                     (state_r == ST_IDLE), status_r};
      end else if (regHit(regAddr, `REG_IRQ_STAT)) begin
        rdOut_nxt = {29'h0, irqStat_r};
      end else if (regHit(regAddr, `REG_IRQ_MASK)) begin
        rdOut_nxt = {29'h0, irqMask_r};
      end else if (regHit(regAddr, `REG_RDATA)) begin
        rdOut_nxt = 32'(rdata_r);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r      <= ST_DOWN;
      count_r      <= 8'h0;
      release_r    <= 1'b0;
      select_r     <= 1'b0;
      cmd_r        <= 3'h0;
      go_r         <= 1'b0;
      addr_r       <= '0;
      wdata_r      <= '0;
      rdata_r      <= '0;
      status_r     <= 8'h80;
      needArray_r  <= 1'b0;
      engineBusy_r <= 1'b0;
      irqStat_r    <= 3'h0;
      irqMask_r    <= 3'h0;
      phase2_r     <= 1'b0;
      rdOut_r      <= 32'h0;
      csN_r        <= 1'b1;
      weN_r        <= 1'b1;
      oeN_r        <= 1'b1;
      drive_r      <= 1'b0;
      pinData_r    <= '0;
    end else begin
      state_r      <= state_nxt;
      count_r      <= count_nxt;
      release_r    <= release_nxt;
      select_r     <= select_nxt;
      cmd_r        <= cmd_nxt;
      go_r         <= go_nxt;
      addr_r       <= addr_nxt;
      wdata_r      <= wdata_nxt;
      rdata_r      <= rdata_nxt;
      status_r     <= status_nxt;
      needArray_r  <= needArray_nxt;
      engineBusy_r <= engineBusy_nxt;
      irqStat_r    <= irqStat_nxt;
      irqMask_r    <= irqMask_nxt;
      phase2_r     <= phase2_nxt;
      rdOut_r      <= rdOut_nxt;
      csN_r        <= csN_nxt;
      weN_r        <= weN_nxt;
      oeN_r        <= oeN_nxt;
      drive_r      <= drive_nxt;
      pinData_r    <= pinData_nxt;
    end
  end

  assign regRdata         = rdOut_r;
  assign irq              = |(irqStat_r & irqMask_r);
  assign resetPowerdown_n = release_r && coreOk && (state_r != ST_DOWN); // [RL6] [RL13]
  assign chipSelect_n     = csN_r || !resetPowerdown_n; // [RL4] [RL5] [RL13]
  assign writeStrobe_n    = weN_r || !resetPowerdown_n; // [RL11] [RL13]
  assign outputGate_n     = oeN_r; // [RL3]
  assign flashAddr        = addr_r; // [RL14]
  assign dataOut          = pinData_r;
  assign dataOe           = drive_r;
endmodule : flash_power_ctrl
`default_nettype wire

// ===== pkg/flash_pm_map.svh
// Purpose: Offsets, field positions, command codes and timing counts of the flash power controller
// Assumes: 25 MHz clock, register port words of 32 bits
// Notes:   Definitions only
`ifndef FLASH_PM_MAP_SVH
`define FLASH_PM_MAP_SVH

`define REG_CTRL        4'h0
`define REG_CMD         4'h1
`define REG_ADDR        4'h2
`define REG_WDATA       4'h3
`define REG_STATUS      4'h4
`define REG_IRQ_STAT    4'h5
`define REG_IRQ_MASK    4'h6
`define REG_RDATA       4'h7

`define CTRL_RESET_REL  0
`define CTRL_SELECT     1

`define CMD_READ        3'h1
`define CMD_WRITE       3'h2
`define CMD_PROGRAM     3'h3
`define CMD_POLL        3'h4

`define CODE_READ_ARRAY 16'h00ff
`define CODE_PROGRAM    16'h0040
`define CODE_READ_STAT  16'h0070

`define SR_SUPPLY_FAULT 3
`define SR_ENGINE_READY 7

`define IRQ_DONE        0
`define IRQ_FAULT       1
`define IRQ_RECOVERED   2

`define CLK_MHZ         25
`define RECOVERY_NS     150
`define RECOVERY_CYC    ((`RECOVERY_NS * `CLK_MHZ + 999) / 1000)
`define STROBE_CYC      3

`endif

// ===== pkg/flash_pm_pkg.sv
// Purpose: Types shared by the flash power controller
// Assumes: Nothing
// Notes:   Constants live in flash_pm_map.svh
`default_nettype none
package flash_pm_pkg;
  typedef logic [3:0]  regAddr_t;
  typedef logic [31:0] word_t;
  typedef enum logic [2:0] {
    ST_DOWN, ST_RECOVER, ST_IDLE, ST_WRITE, ST_READ, ST_POLL
  } fsmState_e;
endpackage : flash_pm_pkg
`default_nettype wire

// ===== tb/flash_power_ctrl_properties.sv
// Purpose: Pin and register-port checks of the flash power controller
// Assumes: Bound to flash_power_ctrl
// Notes:   Sees top ports only
`timescale 1ns/10ps
`default_nettype none
module flash_power_ctrl_properties #(
  parameter int ADDR_W = 22,
  parameter int DATA_W = 16
) (
  input wire logic                clk,
  input wire logic                rst_b,
  input wire logic                regRd,
  input wire flash_pm_pkg::word_t regRdata,
  input wire logic                coreSupplyOk,
  input wire logic                resetPowerdown_n,
  input wire logic                chipSelect_n,
  input wire logic                writeStrobe_n,
  input wire logic                outputGate_n,
  input wire logic [ADDR_W-1:0]   flashAddr,
  input wire logic [DATA_W-1:0]   dataOut,
  input wire logic                dataOe
);
  import flash_pm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_core_low_down: assert property (!coreSupplyOk [*3] |-> !resetPowerdown_n)
    else $error("flash powered with core supply low");
  a_we_needs_cs: assert property (!writeStrobe_n |-> !chipSelect_n)
    else $error("write strobe without select");
  a_we_no_gate: assert property (!writeStrobe_n |-> outputGate_n && dataOe)
    else $error("write strobe with gate low or data released");
  a_gate_no_drive: assert property (!outputGate_n |-> !dataOe && !chipSelect_n)
    else $error("read gate while driving data");
  a_down_quiet: assert property (!resetPowerdown_n |-> chipSelect_n && writeStrobe_n)
    else $error("controls active in power-down");
  a_rd_zero: assert property (!regRd |=> regRdata == '0)
    else $error("read data outside read slot");
  a_we_pulse: assert property ($fell(writeStrobe_n) |-> !writeStrobe_n [*2] ##1 writeStrobe_n)
    else $error("write strobe length wrong");
  a_gate_frame: assert property ($fell(outputGate_n) |-> !outputGate_n [*3] ##1 outputGate_n)
    else $error("read gate length wrong");
  a_data_held: assert property ($rose(writeStrobe_n) |-> $stable(dataOut) && $stable(flashAddr))
    else $error("data moved at write strobe rise");
  c_write: cover property ($rose(writeStrobe_n));
  c_read: cover property ($fell(outputGate_n));
  c_wake: cover property ($rose(resetPowerdown_n));
endmodule : flash_power_ctrl_properties
bind flash_power_ctrl flash_power_ctrl_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
  u_flash_power_ctrl_properties (.clk, .rst_b, .regRd, .regRdata, .coreSupplyOk,
  .resetPowerdown_n, .chipSelect_n, .writeStrobe_n, .outputGate_n, .flashAddr, .dataOut, .dataOe);
`default_nettype wire

// ===== tb/flash_model.sv
// Purpose: Behavioural flash device on the controller's pins
// Assumes: Commands latched on rising write strobe; 16 words kept
// Notes:   Released data pins show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module flash_model #(
  parameter int ADDR_W  = 22,
  parameter int DATA_W  = 16,
  parameter int BUSY_NS = 400
) (
  input  wire logic              progSupplyOk,
  input  wire logic              resetPowerdown_n,
  input  wire logic              chipSelect_n,
  input  wire logic              writeStrobe_n,
  input  wire logic              outputGate_n,
  input  wire logic [ADDR_W-1:0] flashAddr,
  input  wire logic [DATA_W-1:0] dataOut,
  output var  logic [DATA_W-1:0] dataIn
);
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] q, lastQ, pd;
  logic [3:0]        pa;
  logic [7:0]        status;
  logic              busy, progNext, statMode, drive;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = {12'h5a0, 4'(i)};
    {status, busy, progNext, statMode, lastQ} = '0;
  end
  always @(negedge resetPowerdown_n) begin
    {status, busy, progNext, statMode} = '0;
  end
  always @(posedge writeStrobe_n) begin
    if (resetPowerdown_n && !chipSelect_n) begin
      if (progNext) begin
        progNext = 1'b0;
        statMode = 1'b1;
        pa = flashAddr[3:0];
        pd = dataOut;
        if (!progSupplyOk) status = 8'h08;
        else begin
          busy = 1'b1;
          fork
            begin #(BUSY_NS); if (busy) mem[pa] = pd; busy = 1'b0; end
          join_none
        end
      end else begin
        progNext = (dataOut == 16'h0040);
        if (dataOut == 16'h0070) statMode = 1'b1;
        if (dataOut == 16'h00ff) statMode = 1'b0;
      end
    end
  end
  assign drive = resetPowerdown_n && !chipSelect_n && !outputGate_n && writeStrobe_n;
  assign q = statMode ? {8'h00, !busy, status[6:0]} : mem[flashAddr[3:0]];
  always @(q or drive) if (drive) lastQ = q;
  assign dataIn = drive ? q : ~lastQ;
endmodule : flash_model
`default_nettype wire

// ===== tb/flash_power_ctrl_tb.sv
// Purpose: Register-level test of the flash power controller
// Assumes: Flash model on the pins
// Notes:   Flash words start as 12'h5a0 and the word index
`timescale 1ns/10ps
`default_nettype none
`include "flash_pm_map.svh"
module flash_power_ctrl_tb;
  import flash_pm_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        coreSupplyOk = 1'b1;
  logic        progSupplyOk = 1'b1;
  regAddr_t    regAddr = '0;
  word_t       regWdata = '0;
  word_t       regRdata, rd;
  logic        irq, resetPowerdown_n, chipSelect_n, writeStrobe_n, outputGate_n, dataOe;
  logic [21:0] flashAddr;
  logic [15:0] dataOut, dataIn;
  int          num_errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  always #20 clk = ~clk;
  flash_power_ctrl u_flash_power_ctrl (.clk, .rst_b, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .irq, .coreSupplyOk, .progSupplyOk, .resetPowerdown_n, .chipSelect_n,
    .writeStrobe_n, .outputGate_n, .flashAddr, .dataOut, .dataOe, .dataIn);
  flash_model u_flash_model (.progSupplyOk, .resetPowerdown_n, .chipSelect_n,
    .writeStrobe_n, .outputGate_n, .flashAddr, .dataOut, .dataIn);
  task automatic end_of_test();
    $display("Mismatches %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic chk(string nm, word_t seen, word_t exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(regAddr_t a, word_t d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rdr(regAddr_t a);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask : rdr
  task automatic waitBit(regAddr_t a, int b);
    for (int i = 0; i < 200; i++) begin
      rdr(a);
      if (rd[b] === 1'b1) return;
    end
    chk("wait", 32'h0, 32'h1);
  endtask : waitBit
  task automatic cmd(word_t c);
    wr(`REG_CMD, c);
    repeat (8) @(posedge clk);
    waitBit(`REG_STATUS, 8);
  endtask : cmd
  task automatic rdArr(word_t a, word_t exp);
    wr(`REG_ADDR, a);
    cmd(`CMD_READ);
    rdr(`REG_RDATA);
    chk("array", rd & 32'hffff, exp);
  endtask : rdArr
  task automatic prog(word_t a, word_t d);
    wr(`REG_ADDR, a);
    wr(`REG_WDATA, d);
    cmd(`CMD_PROGRAM);
  endtask : prog
  task automatic chkIrq(word_t exp);
    @(posedge clk);
    #1 chk("irq", {31'h0, irq}, exp);
  endtask : chkIrq
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    #1 chk("pins", {26'h0, resetPowerdown_n, chipSelect_n, writeStrobe_n, outputGate_n,
      dataOe, irq}, 32'h1c);
    rdr(4'h9);
    chk("unmapped", rd, 32'h0);
    rdr(`REG_STATUS);
    chk("status", rd & 32'h1f00, 32'h1800);
    wr(`REG_IRQ_MASK, 32'h7);
    wr(`REG_CTRL, 32'h1);
    waitBit(`REG_IRQ_STAT, `IRQ_RECOVERED);
    chk("wake", {31'h0, resetPowerdown_n}, 32'h1);
    chkIrq(32'h1);
    wr(`REG_IRQ_STAT, 32'h4);
    chkIrq(32'h0);
    rdArr(32'h5, 32'h5a05);
    prog(32'h3, 32'h1234);
    rdr(`REG_STATUS);
    chk("need array", rd & 32'h400, 32'h400);
    wr(`REG_WDATA, 32'h70);
    cmd(`CMD_WRITE);
    for (int i = 0; i < 50; i++) begin
      cmd(`CMD_POLL);
      rdr(`REG_STATUS);
      if (rd[7] === 1'b1) break;
    end
    chk("ready", rd & 32'hff, 32'h80);
    wr(`REG_WDATA, 32'hff);
    cmd(`CMD_WRITE);
    rdr(`REG_STATUS);
    chk("need array", rd & 32'h400, 32'h0);
    rdArr(32'h3, 32'h1234);
    wr(`REG_IRQ_STAT, 32'h7);
    progSupplyOk <= 1'b0;
    repeat (3) @(posedge clk);
    prog(32'h6, 32'hbeef);
    rdr(`REG_STATUS);
    chk("supply fault", rd & 32'h8, 32'h8);
    rdr(`REG_IRQ_STAT);
    chk("fault irq", rd & 32'h2, 32'h2);
    wr(`REG_IRQ_MASK, 32'h5);
    chkIrq(32'h0);
    wr(`REG_IRQ_MASK, 32'h7);
    rdArr(32'h6, 32'h5a06);
    progSupplyOk <= 1'b1;
    wr(`REG_IRQ_STAT, 32'h7);
    prog(32'h2, 32'h7777);
    wr(`REG_CTRL, 32'h0);
    rdr(`REG_IRQ_STAT);
    chk("abort", rd & 32'h2, 32'h2);
    chk("down", {31'h0, resetPowerdown_n}, 32'h0);
    wr(`REG_CTRL, 32'h1);
    waitBit(`REG_IRQ_STAT, `IRQ_RECOVERED);
    rdArr(32'h0, 32'h5a00);
    wr(`REG_CTRL, 32'h3);
    repeat (2) @(posedge clk);
    #1 chk("held select", {31'h0, chipSelect_n}, 32'h0);
    coreSupplyOk <= 1'b0;
    repeat (4) @(posedge clk);
    chk("core low", {30'h0, resetPowerdown_n, chipSelect_n}, 32'h1);
    end_of_test();
  end
endmodule : flash_power_ctrl_tb
`default_nettype wire
